// [common/gsl_map.vh]
// constants for the general-purpose pin and status indicator block
`ifndef GSL_MAP_VH
`define GSL_MAP_VH

// number of general-purpose pins
`define GSL_PIN_COUNT       3

// pin index that carries each indicator function
`define GSL_PIN_SPEED       0
`define GSL_PIN_LINKACT     1
`define GSL_PIN_DUPLEX      2

// clock rate and indicator pulse timing
`define GSL_CLK_KHZ         10000
`define GSL_BLINK_MS        80
`define GSL_BLINK_CNT_W     20

// configuration defaults after reset: every pin an input, no indicator
`define GSL_RST_OUTPUT      3'h0
`define GSL_RST_OPEN_DRAIN  3'h0
`define GSL_RST_DATA        3'h0
`define GSL_RST_LED_EN      3'h0

// link-and-activity indicator states
`define GSL_ST_NOLINK       2'h0
`define GSL_ST_SOLID        2'h1
`define GSL_ST_OFF          2'h2
`define GSL_ST_HOLD         2'h3

`endif

// [hw/gsl_blink.v]
// link-and-activity indicator sequencer with off pulse and on hold
`timescale 1ns/1ps
`default_nettype none
`include "gsl_map.vh"

module gsl_blink #(
  parameter HOLD_CYCLES = `GSL_BLINK_MS * `GSL_CLK_KHZ,
  parameter CNT_W       = `GSL_BLINK_CNT_W
) (
  input  wire clk,
  input  wire sys_rst,
  input  wire link_up,
  input  wire activity,
  output reg  link_activity_indicator_n
);

  // last count of a phase, cut to the counter width on purpose
  localparam [31:0]      LAST_W = HOLD_CYCLES - 1;
  localparam [CNT_W-1:0] LAST   = LAST_W[CNT_W-1:0];
  localparam [1:0] ST_NOLINK = `GSL_ST_NOLINK;
  localparam [1:0] ST_SOLID  = `GSL_ST_SOLID;
  localparam [1:0] ST_OFF    = `GSL_ST_OFF;
  localparam [1:0] ST_HOLD   = `GSL_ST_HOLD;

  reg [1:0]       state;
  reg [1:0]       next_state;
  reg [CNT_W-1:0] cnt;
  reg             pending;
  reg             next_pending;
  wire            cnt_done;

  assign cnt_done = (cnt == LAST);

  // next state: link loss wins over every timed phase
  always @* begin
    next_state   = state;
    next_pending = pending | activity; // [RULE11]
    case (state)
      ST_NOLINK: begin
        next_pending = 1'b0;
        if (link_up)
          next_state = ST_SOLID; // [RULE6]
      end
      ST_SOLID: begin
        next_pending = 1'b0;
        if (activity)
          next_state = ST_OFF; // [RULE7]
      end
      ST_OFF: begin
        if (cnt_done) begin
          next_state = ST_HOLD; // [RULE8]
        end
      end
      ST_HOLD: begin
        if (cnt_done) begin
          next_pending = 1'b0;
          if (pending | activity)
            next_state = ST_OFF; // [RULE8] [RULE11]
          else
            next_state = ST_SOLID; // [RULE6]
        end
      end
      default: begin
        next_state   = ST_NOLINK;
        next_pending = 1'b0;
      end
    endcase
    if (!link_up) begin
      next_state   = ST_NOLINK;
      next_pending = 1'b0;
    end
  end

  // state, interval counter and indicator level
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin // [RULE10]
      state                     <= ST_NOLINK;
      cnt                       <= {CNT_W{1'b0}};
      pending                   <= 1'b0;
      link_activity_indicator_n <= 1'b1;
    end else begin
      state   <= next_state;
      pending <= next_pending;
      if (next_state != state)
        cnt <= {CNT_W{1'b0}}; // each phase times from zero [RULE11]
      else if (!cnt_done)
        cnt <= cnt + 1'b1;
      // lamp on while solid or holding, off in a pulse or with no link
      link_activity_indicator_n <= ~((next_state == ST_SOLID) |
                                     (next_state == ST_HOLD)); // [RULE6]
    end
  end

endmodule // gsl_blink
`default_nettype wire

// [hw/gsl_pins.v]
// three general-purpose pins with open-drain status indicator functions
//
// Functional notes
// RULE1: each pin independently push-pull output, open-drain output or input.
// RULE2: each pin can carry its status indicator instead of gpio.
// RULE3: indicator pins are open-drain: drive low, release when high.
// RULE4: speed indicator low at 100 Mb, during auto-negotiation, or unplugged.
// RULE5: speed indicator high only while link runs at 10 Mb.
// RULE6: link-activity indicator low while a valid link is present and idle.
// RULE7: activity makes link-activity indicator go high for 80 ms.
// RULE8: after each off pulse, low at least 80 ms; repeat only on activity.
// RULE9: duplex indicator low in full duplex, released high otherwise.
// RULE10: reset returns all logic and configuration to defaults.
// RULE11: counter times the pulses; activity during hold is latched.
`timescale 1ns/1ps
`default_nettype none
`include "gsl_map.vh"

module gsl_pins #(
  parameter NPINS       = `GSL_PIN_COUNT,
  parameter BLINK_MS    = `GSL_BLINK_MS,
  parameter HOLD_CYCLES = `GSL_BLINK_MS * `GSL_CLK_KHZ,
  parameter CNT_W       = `GSL_BLINK_CNT_W
) (
  input  wire             clk,
  input  wire             sys_rst,
  // configuration strobe and fields, one bit per pin
  input  wire             cfg_write,
  input  wire [NPINS-1:0] cfg_output,
  input  wire [NPINS-1:0] cfg_open_drain,
  input  wire [NPINS-1:0] cfg_data,
  input  wire [NPINS-1:0] cfg_led_enable,
  // configuration as currently held
  output reg  [NPINS-1:0] cfg_output_q,
  output reg  [NPINS-1:0] cfg_open_drain_q,
  output reg  [NPINS-1:0] cfg_data_q,
  output reg  [NPINS-1:0] cfg_led_enable_q,
  // link state from the phy
  input  wire             phy_speed_100,
  input  wire             phy_autoneg_busy,
  input  wire             phy_link_up,
  input  wire             phy_activity,
  input  wire             phy_full_duplex,
  // pin level as sampled for software
  output reg  [NPINS-1:0] gpio_rd_data,
  // indicator levels, active low
  output reg              speed_indicator_n,
  output wire             link_activity_indicator_n,
  output reg              duplex_indicator_n,
  // pad signals: input, output and output enable
  input  wire [NPINS-1:0] pin_in,
  output reg  [NPINS-1:0] pin_out,
  output reg  [NPINS-1:0] pin_oe
);

  // indicator level per pin position, low means lamp on
  wire [NPINS-1:0] led_level_n;
  // gpio drive request per pin before registering
  wire [NPINS-1:0] next_pin_out;
  wire [NPINS-1:0] next_pin_oe;
  // speed and duplex indicator next values
  wire             next_speed_n;
  wire             next_duplex_n;

  // configuration store, loaded as a whole on the strobe
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin // [RULE10]
      cfg_output_q     <= `GSL_RST_OUTPUT;
      cfg_open_drain_q <= `GSL_RST_OPEN_DRAIN;
      cfg_data_q       <= `GSL_RST_DATA;
      cfg_led_enable_q <= `GSL_RST_LED_EN;
    end else if (cfg_write) begin
      cfg_output_q     <= cfg_output;     // [RULE1]
      cfg_open_drain_q <= cfg_open_drain; // [RULE1]
      cfg_data_q       <= cfg_data;
      cfg_led_enable_q <= cfg_led_enable; // [RULE2]
    end
  end

  // speed: high only for an established 10 Mb link
  assign next_speed_n = phy_link_up & ~phy_autoneg_busy &
                        ~phy_speed_100; // [RULE4] [RULE5]

  // duplex: low only while a full-duplex link is up
  assign next_duplex_n = ~(phy_link_up & phy_full_duplex); // [RULE9]

  // registered speed and duplex indicators
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin // [RULE10]
      speed_indicator_n  <= 1'b0;
      duplex_indicator_n <= 1'b1;
    end else begin
      speed_indicator_n  <= next_speed_n;  // [RULE4] [RULE5]
      duplex_indicator_n <= next_duplex_n; // [RULE9]
    end
  end

  // link-and-activity sequencer with its pulse timer
  gsl_blink #(
    .HOLD_CYCLES (HOLD_CYCLES),
    .CNT_W       (CNT_W)
  ) u_blink (
    .clk                       (clk),
    .sys_rst                   (sys_rst),
    .link_up                   (phy_link_up),
    .activity                  (phy_activity),
    .link_activity_indicator_n (link_activity_indicator_n)
  ); // [RULE7] [RULE8] [RULE11]

  // indicator function assigned to each pin position
  assign led_level_n[`GSL_PIN_SPEED]   = speed_indicator_n;
  assign led_level_n[`GSL_PIN_LINKACT] = link_activity_indicator_n;
  assign led_level_n[`GSL_PIN_DUPLEX]  = duplex_indicator_n;

  // per-pin drive selection
  genvar i;
  generate
    for (i = 0; i < NPINS; i = i + 1) begin : g_pin
      // indicator mode always open-drain; gpio per its configuration
      assign next_pin_out[i] = cfg_led_enable_q[i] ? 1'b0 :
                               (cfg_open_drain_q[i] ? 1'b0 : cfg_data_q[i]);
      assign next_pin_oe[i]  = cfg_led_enable_q[i] ? ~led_level_n[i] : // [RULE3]
                               (cfg_output_q[i] &
                                (~cfg_open_drain_q[i] | ~cfg_data_q[i])); // [RULE1]
    end
  endgenerate

  // pad drive and input sample registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin // [RULE10]
      pin_out      <= {NPINS{1'b0}};
      pin_oe       <= {NPINS{1'b0}};
      gpio_rd_data <= {NPINS{1'b0}};
    end else begin
      pin_out      <= next_pin_out; // [RULE2]
      pin_oe       <= next_pin_oe;  // [RULE3]
      gpio_rd_data <= pin_in;       // [RULE1]
    end
  end

endmodule // gsl_pins
`default_nettype wire

// [dv/gsl_pins_asserts.sv]
// assertions on the gpio and status indicator pins
`timescale 1ns/1ps
`default_nettype none
module gsl_pins_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [2:0] cfg_output_q,
  input wire logic [2:0] cfg_open_drain_q,
  input wire logic [2:0] cfg_data_q,
  input wire logic [2:0] cfg_led_enable_q,
  input wire logic       phy_speed_100,
  input wire logic       phy_autoneg_busy,
  input wire logic       phy_link_up,
  input wire logic       phy_full_duplex,
  input wire logic       speed_indicator_n,
  input wire logic       link_activity_indicator_n,
  input wire logic       duplex_indicator_n,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe
);
  // short names for the indicators and the gpio drive modes
  wire       lnk = phy_link_up;
  wire       la = link_activity_indicator_n;
  wire       slow = lnk & ~phy_autoneg_busy & ~phy_speed_100;
  wire [2:0] ind_n = {duplex_indicator_n, la, speed_indicator_n};
  wire [2:0] led = cfg_led_enable_q;
  wire [2:0] pp = cfg_output_q & ~cfg_open_drain_q & ~led;
  wire [2:0] od = cfg_output_q & cfg_open_drain_q & ~led;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_spd_lo; !slow |=> !speed_indicator_n; endproperty
  a_spd_lo: assert property (p_spd_lo) else $error("speed low");
  property p_spd_hi; slow |=> speed_indicator_n; endproperty
  a_spd_hi: assert property (p_spd_hi) else $error("speed high");
  property p_dup_on; lnk && phy_full_duplex |=> !duplex_indicator_n; endproperty
  a_dup_on: assert property (p_dup_on) else $error("duplex on");
  property p_dup_off; !phy_full_duplex |=> duplex_indicator_n; endproperty
  a_dup_off: assert property (p_dup_off) else $error("duplex off");
  property p_off; $rose(la) && $past(lnk) |-> la [*8]; endproperty
  a_off: assert property (p_off) else $error("off pulse");
  property p_hold; $fell(la) && $past(lnk, 2) |-> !la [*8]; endproperty
  a_hold: assert property (p_hold) else $error("on hold");
  property p_led; led != 3'h0 |=> ((pin_oe ^ ~$past(ind_n)) & $past(led))
    == 3'h0 && (pin_out & $past(led)) == 3'h0; endproperty
  a_led: assert property (p_led) else $error("led drive");
  property p_pp; pp != 3'h0 |=>
    ((~pin_oe | (pin_out ^ $past(cfg_data_q))) & $past(pp)) == 3'h0; endproperty
  a_pp: assert property (p_pp) else $error("push-pull");
  property p_od; od != 3'h0 |=>
    ((pin_out | (pin_oe ^ ~$past(cfg_data_q))) & $past(od)) == 3'h0; endproperty
  a_od: assert property (p_od) else $error("open drain");
  c_blink: cover property ($rose(la) && lnk);
  c_slow: cover property (speed_indicator_n && led[0]);
  c_od: cover property (od != 3'h0);
endmodule // gsl_pins_chk
bind gsl_pins gsl_pins_chk u_chk (.clk, .sys_rst, .cfg_output_q,
  .cfg_open_drain_q, .cfg_data_q, .cfg_led_enable_q, .phy_speed_100,
  .phy_autoneg_busy, .phy_link_up, .phy_full_duplex, .speed_indicator_n,
  .link_activity_indicator_n, .duplex_indicator_n, .pin_out, .pin_oe);
`default_nettype wire

// [dv/gsl_board.sv]
// board side of the pins: pull-ups and optional drivers
`timescale 1ns/1ps
`default_nettype none
module gsl_board (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] ext_en,
  input  wire logic [2:0] ext_val,
  output logic      [2:0] pin_in
);
  // pad driver wins, then a board driver, else the pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (~ext_en | ext_val));
endmodule // gsl_board
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the gpio and status indicator pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk, sys_rst, cfg_write, s100, an, lnk, act, fd, sn, la, dn;
  logic [2:0] co, cd, cv, cl, qo, qd, qv, ql, rd, pi, po, pe, xe, xv, ex;
  int         error_cnt, n_checks, n, i;
  gsl_pins #(.HOLD_CYCLES(8), .CNT_W(4)) DUT (.clk(clk), .sys_rst(sys_rst),
    .cfg_write(cfg_write), .cfg_output(co), .cfg_open_drain(cd),
    .cfg_data(cv), .cfg_led_enable(cl), .cfg_output_q(qo),
    .cfg_open_drain_q(qd), .cfg_data_q(qv), .cfg_led_enable_q(ql),
    .phy_speed_100(s100), .phy_autoneg_busy(an), .phy_link_up(lnk),
    .phy_activity(act), .phy_full_duplex(fd), .gpio_rd_data(rd),
    .speed_indicator_n(sn), .link_activity_indicator_n(la),
    .duplex_indicator_n(dn), .pin_in(pi), .pin_out(po), .pin_oe(pe));
  gsl_board board (.pin_out(po), .pin_oe(pe), .ext_en(xe), .ext_val(xv),
    .pin_in(pi));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("errors=%0d checks=%0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // load a configuration, wait until the pads follow it
  task cfg(input logic [2:0] o, d, v, l);
    {co, cd, cv, cl} = {o, d, v, l};
    cfg_write = 1;
    cyc(1);
    cfg_write = 0;
    cyc(1);
  endtask
  // count cycles the link lamp stays at one level, bounded
  task cnt(input logic lv, input int e);
    n = 0;
    while (la === lv && n < 40) begin
      cyc(1);
      n++;
    end
    if (n == 40) begin
      error_cnt++;
      finish_test;
    end
    chk(n, e);
  endtask
  task t_rst;
    chk({qo | qd | qv | ql | pe | po, sn, la, dn}, 8'h03);
  endtask
  task t_gpio;
    cfg(3'h3, 3'h2, 3'h1, 3'h0);
    chk({pe, po}, {3'h3, 3'h1});
    cyc(1);
    chk(rd, 3'h5);
    cfg(3'h3, 3'h2, 3'h2, 3'h0);
    chk({pe, po}, {3'h1, 3'h0});
    cyc(1);
    chk(rd, 3'h6);
  endtask
  task t_ind;
    xe = 3'h0;
    cfg(3'h7, 3'h0, 3'h7, 3'h7);
    for (i = 0; i < 16; i++) begin
      {s100, an, lnk, fd} = i[3:0];
      cyc(2);
      ex = {!(lnk & fd), !lnk, lnk & !an & !s100};
      chk({dn, la, sn}, ex);
      chk({po, pe}, {3'h0, ~ex});
    end
  endtask
  task t_blink;
    {s100, an, fd, lnk} = 4'h1;
    cyc(2);
    chk(la, 0);
    act = 1;
    cyc(2);
    act = 0;
    cnt(1, 7);
    cnt(0, 8);
    cnt(1, 8);
    cyc(20);
    chk(la, 0);
    lnk = 0;
    cyc(2);
    chk(la, 1);
  endtask
  initial begin
    {sys_rst, cfg_write, co, cd, cv, cl} = 14'h2000;
    {s100, an, lnk, act, fd, error_cnt, n_checks} = 0;
    {xe, xv} = 6'h24;
    cyc(4);
    t_rst;
    sys_rst = 0;
    t_gpio;
    t_ind;
    t_blink;
    sys_rst = 1;
    cyc(1);
    t_rst;
    sys_rst = 0;
    cyc(2);
    t_rst;
    finish_test;
  end
endmodule // tb
`default_nettype wire
